// >>> src/oag_map.svh
// Constants of the operand address generator
`ifndef OAG_MAP_SVH
`define OAG_MAP_SVH

// ----------------------------------------
// Prefix bytes
// ----------------------------------------
`define OAG_PFX_ALT      8'h90
`define OAG_PFX_IND      8'h92
`define OAG_PFX_IND_Y    8'h91

// ----------------------------------------
// Opcode classes, high nibble
// ----------------------------------------
`define OAG_CL_BITREL    4'h0
`define OAG_CL_BIT       4'h1
`define OAG_CL_REL       4'h2
`define OAG_CL_MEM_DIR   4'h3
`define OAG_CL_MEM_IDXS  4'h6
`define OAG_CL_MEM_IDX0  4'h7
`define OAG_CL_IMM       4'hA
`define OAG_CL_DIR_S     4'hB
`define OAG_CL_DIR_L     4'hC
`define OAG_CL_IDX_L     4'hD
`define OAG_CL_IDX_S     4'hE
`define OAG_CL_IDX_0     4'hF

// ----------------------------------------
// Address space and lengths
// ----------------------------------------
`define OAG_PAGE0_HI     8'h00
`define OAG_IDXS_MAX     16'h01FE
`define OAG_LEN_OPC      3'h1
`define OAG_PTR_WORD     2'h2
`define OAG_PTR_BYTE     2'h1

`endif

// >>> src/oag_pkg.sv
// Types of the operand address generator
package oag_pkg;

    typedef enum logic [4:0] {
        OAG_INH      = 5'b00000,
        OAG_IMM      = 5'b00001,
        OAG_DIR_S    = 5'b00010,
        OAG_DIR_L    = 5'b00011,
        OAG_IDX_0    = 5'b00100,
        OAG_IDX_S    = 5'b00101,
        OAG_IDX_L    = 5'b00110,
        OAG_IND_S    = 5'b00111,
        OAG_IND_L    = 5'b01000,
        OAG_IDXIND_S = 5'b01001,
        OAG_IDXIND_L = 5'b01010,
        OAG_REL_D    = 5'b01011,
        OAG_REL_I    = 5'b01100,
        OAG_BIT_D    = 5'b01101,
        OAG_BIT_I    = 5'b01110,
        OAG_BITREL_D = 5'b01111,
        OAG_BITREL_I = 5'b10000
    } oag_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_OPC      = 3'b001,
        ST_OPND     = 3'b010,
        ST_PTR_REQ  = 3'b011,
        ST_PTR_WAIT = 3'b100,
        ST_CALC     = 3'b101
    } oag_state_e;

    typedef logic [15:0] oag_addr_t;

endpackage

// >>> src/oag_mode_decode.sv
// Opcode to addressing mode decoder
`timescale 1ns/10ps
`include "oag_map.svh"

module oag_mode_decode (
    // Instruction byte and prefixes
    input  wire logic [7:0]        opcode,
    input  wire logic              pfx_alt,
    input  wire logic              pfx_ind,
    input  wire logic              pfx_ind_y,
    // Decoded mode
    output oag_pkg::oag_mode_e     mode,
    output logic      [1:0]        extra,
    output logic                   use_y,
    output logic                   short_only
);

    logic ind;

    always_comb begin
        ind        = pfx_ind | pfx_ind_y;
        use_y      = pfx_alt | pfx_ind_y;
        short_only = 1'b0;
        case (opcode[7:4])
            `OAG_CL_BITREL: begin
                mode       = ind ? oag_pkg::OAG_BITREL_I : oag_pkg::OAG_BITREL_D;
                short_only = 1'b1;
            end
            `OAG_CL_BIT: begin
                mode       = ind ? oag_pkg::OAG_BIT_I : oag_pkg::OAG_BIT_D;
                short_only = 1'b1;
            end
            `OAG_CL_REL:      mode = ind ? oag_pkg::OAG_REL_I : oag_pkg::OAG_REL_D;
            `OAG_CL_MEM_DIR: begin
                mode       = ind ? oag_pkg::OAG_IND_S : oag_pkg::OAG_DIR_S;
                short_only = 1'b1;
            end
            `OAG_CL_MEM_IDXS: begin
                mode       = ind ? oag_pkg::OAG_IDXIND_S : oag_pkg::OAG_IDX_S;
                short_only = 1'b1;
            end
            `OAG_CL_MEM_IDX0: begin
                mode       = oag_pkg::OAG_IDX_0;
                short_only = 1'b1;
            end
            `OAG_CL_IMM:      mode = oag_pkg::OAG_IMM;
            `OAG_CL_DIR_S:    mode = ind ? oag_pkg::OAG_IND_S : oag_pkg::OAG_DIR_S;
            `OAG_CL_DIR_L:    mode = ind ? oag_pkg::OAG_IND_L : oag_pkg::OAG_DIR_L;
            `OAG_CL_IDX_L:    mode = ind ? oag_pkg::OAG_IDXIND_L : oag_pkg::OAG_IDX_L;
            `OAG_CL_IDX_S:    mode = ind ? oag_pkg::OAG_IDXIND_S : oag_pkg::OAG_IDX_S;
            `OAG_CL_IDX_0:    mode = oag_pkg::OAG_IDX_0;
            default:          mode = oag_pkg::OAG_INH;
        endcase
    end

    // Bytes after the opcode
    always_comb begin
        case (mode)
            oag_pkg::OAG_INH, oag_pkg::OAG_IDX_0:           extra = 2'd0;
            oag_pkg::OAG_DIR_L, oag_pkg::OAG_IDX_L,
            oag_pkg::OAG_BITREL_D, oag_pkg::OAG_BITREL_I:   extra = 2'd2;
            default:                                        extra = 2'd1;
        endcase
    end

endmodule

// >>> src/oag_core.sv
// Operand effective address generator
`timescale 1ns/10ps
`include "oag_map.svh"
// Operation
// - Seventeen addressing modes in seven groups are decoded.
// - Short forms reach page zero, short indexed up to 1FE; long forms reach 64 Kbyte.
// - Memory-to-memory instructions decode to short forms only.
// - Inherent instructions are one opcode byte, no operand bytes.
// - Immediate takes the byte after the opcode as the value.
// - Short direct uses one byte as page-zero address.
// - Long direct uses two bytes as a 16-bit address.
// - Indexed adds index and offset unsigned, no sign extension.
// - No-offset indexed uses the index alone; Y costs a prefix byte.
// - Short indexed adds one offset byte, reaching up to 1FE.
// - Long indexed adds a two-byte offset across 64 Kbyte.
// - Indirect reads the operand address from a page-zero pointer.
// - Short indirect reads one pointer byte as page-zero address.
// - Long indirect reads a two-byte pointer as 16-bit address.
// - Relative target is from PC of the next instruction, -128..+127.
// - Relative offset is an 8-bit signed two's complement value.
// - Indirect indexed adds the index to the read pointer, unsigned.
// - Prefix 90 selects the secondary index register.

module oag_core (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Instruction byte stream
    input  wire logic                fetch_valid,
    input  wire logic [7:0]          fetch_byte,
    input  wire logic [15:0]         fetch_pc,
    // Index registers
    input  wire logic [7:0]          idx_x,
    input  wire logic [7:0]          idx_y,
    // Pointer read port
    output logic                     mem_rd_req,
    output logic [15:0]              mem_rd_addr,
    input  wire logic                mem_rd_valid,
    input  wire logic [7:0]          mem_rd_data,
    // Result
    output logic                     addr_valid,
    output oag_pkg::oag_mode_e       mode_out,
    output logic [15:0]              operand_addr,
    output logic [7:0]               operand_value,
    output logic [15:0]              jump_target,
    output logic [2:0]               bit_number,
    output logic [2:0]               instr_len,
    output logic                     use_y_out,
    output logic                     short_only_out
);

    oag_pkg::oag_state_e state;
    oag_pkg::oag_mode_e  mode;
    oag_pkg::oag_mode_e  dec_mode;
    logic [1:0]          dec_extra;
    logic                dec_use_y;
    logic                dec_short;
    logic                pfx_alt;
    logic                pfx_ind;
    logic                pfx_ind_y;
    logic                had_pfx;
    logic [1:0]          extra;
    logic [1:0]          cnt;
    logic [1:0]          ptr_need;
    logic [1:0]          ptr_cnt;
    logic                use_y;
    logic                short_only;
    logic [2:0]          bit_sel;
    logic [15:0]         start_pc;
    logic [7:0]          opnd [0:1];
    logic [7:0]          ptr  [0:1];
    logic                is_pfx;
    logic                take_opc;
    logic                last_opnd;
    logic                indirect;
    logic [2:0]          len;
    logic [15:0]         pc_next;
    logic [15:0]         idx;
    logic [15:0]         ptr_word;
    logic [15:0]         next_addr;
    logic [15:0]         next_target;
    logic [7:0]          rel_off;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    oag_mode_decode oag_mode_decode_i (.opcode(fetch_byte), .pfx_alt(pfx_alt), .pfx_ind(pfx_ind),
        .pfx_ind_y(pfx_ind_y), .mode(dec_mode), .extra(dec_extra), .use_y(dec_use_y), .short_only(dec_short));

    assign is_pfx    = fetch_byte inside {`OAG_PFX_ALT, `OAG_PFX_IND, `OAG_PFX_IND_Y};
    assign take_opc  = fetch_valid && ((state == oag_pkg::ST_OPC) ||
                       ((state == oag_pkg::ST_IDLE) && !is_pfx));
    assign last_opnd = (state == oag_pkg::ST_OPND) && fetch_valid && (cnt == extra - 2'd1);
    assign indirect  = mode inside {oag_pkg::OAG_IND_S, oag_pkg::OAG_IND_L, oag_pkg::OAG_IDXIND_S,
                       oag_pkg::OAG_IDXIND_L, oag_pkg::OAG_REL_I, oag_pkg::OAG_BIT_I,
                       oag_pkg::OAG_BITREL_I};
    assign len       = `OAG_LEN_OPC + {2'b00, had_pfx} + {1'b0, extra};

    // ----------------------------------------
    // Prefix capture and sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset || take_opc) begin
            pfx_alt   <= 1'b0;
            pfx_ind   <= 1'b0;
            pfx_ind_y <= 1'b0;
        end else if ((state == oag_pkg::ST_IDLE) && fetch_valid && is_pfx) begin
            pfx_alt   <= (fetch_byte == `OAG_PFX_ALT);
            pfx_ind   <= (fetch_byte == `OAG_PFX_IND);
            pfx_ind_y <= (fetch_byte == `OAG_PFX_IND_Y);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= oag_pkg::ST_IDLE;
            mode       <= oag_pkg::OAG_INH;
            extra      <= 2'd0;
            cnt        <= 2'd0;
            ptr_cnt    <= 2'd0;
            ptr_need   <= 2'd0;
            had_pfx    <= 1'b0;
            use_y      <= 1'b0;
            short_only <= 1'b0;
            bit_sel    <= 3'd0;
            start_pc   <= 16'h0000;
            mem_rd_req <= 1'b0;
            mem_rd_addr <= 16'h0000;
        end else begin
            mem_rd_req <= 1'b0;
            case (state)
                oag_pkg::ST_IDLE, oag_pkg::ST_OPC: begin
                    if (fetch_valid && (state == oag_pkg::ST_IDLE)) begin
                        start_pc <= fetch_pc;
                        had_pfx  <= is_pfx;
                    end
                    if (take_opc) begin
                        mode       <= dec_mode;
                        extra      <= dec_extra;
                        use_y      <= dec_use_y;
                        short_only <= dec_short;
                        bit_sel    <= fetch_byte[3:1];
                        cnt        <= 2'd0;
                        ptr_cnt    <= 2'd0;
                        ptr_need   <= ((dec_mode == oag_pkg::OAG_IND_L) || (dec_mode == oag_pkg::OAG_IDXIND_L)) ?
                                      `OAG_PTR_WORD : `OAG_PTR_BYTE;
                        state      <= (dec_extra == 2'd0) ? oag_pkg::ST_CALC : oag_pkg::ST_OPND;
                    end else if (fetch_valid) begin
                        state <= oag_pkg::ST_OPC;
                    end
                end
                oag_pkg::ST_OPND: begin
                    if (fetch_valid) begin
                        cnt <= cnt + 2'd1;
                        if (last_opnd) begin
                            state <= indirect ? oag_pkg::ST_PTR_REQ : oag_pkg::ST_CALC;
                        end
                    end
                end
                oag_pkg::ST_PTR_REQ: begin
                    mem_rd_req  <= 1'b1;
                    mem_rd_addr <= {`OAG_PAGE0_HI, opnd[0] + {6'd0, ptr_cnt}};
                    state       <= oag_pkg::ST_PTR_WAIT;
                end
                oag_pkg::ST_PTR_WAIT: begin
                    if (mem_rd_valid) begin
                        ptr_cnt <= ptr_cnt + 2'd1;
                        state   <= (ptr_cnt + 2'd1 == ptr_need) ? oag_pkg::ST_CALC : oag_pkg::ST_PTR_REQ;
                    end
                end
                default:          state <= oag_pkg::ST_IDLE;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_byte
            always_ff @(posedge clk) begin
                if (reset) begin
                    opnd[g] <= 8'h00;
                    ptr[g]  <= 8'h00;
                end else begin
                    if ((state == oag_pkg::ST_OPND) && fetch_valid && (cnt == 2'(g))) opnd[g] <= fetch_byte;
                    if ((state == oag_pkg::ST_PTR_WAIT) && mem_rd_valid && (ptr_cnt == 2'(g))) ptr[g] <= mem_rd_data;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Address arithmetic and result
    // ----------------------------------------
    always_comb begin
        idx      = {8'h00, use_y ? idx_y : idx_x};
        ptr_word = (ptr_need == `OAG_PTR_WORD) ? {ptr[0], ptr[1]} : {`OAG_PAGE0_HI, ptr[0]};
        pc_next  = start_pc + {13'd0, len};
        case (mode)
            oag_pkg::OAG_DIR_S, oag_pkg::OAG_BIT_D,
            oag_pkg::OAG_BITREL_D:  next_addr = {`OAG_PAGE0_HI, opnd[0]};
            oag_pkg::OAG_DIR_L:     next_addr = {opnd[0], opnd[1]};
            oag_pkg::OAG_IDX_0:     next_addr = idx;
            oag_pkg::OAG_IDX_S:     next_addr = {`OAG_PAGE0_HI, opnd[0]} + idx;
            oag_pkg::OAG_IDX_L:     next_addr = {opnd[0], opnd[1]} + idx;
            oag_pkg::OAG_IND_S, oag_pkg::OAG_IND_L,
            oag_pkg::OAG_BIT_I, oag_pkg::OAG_BITREL_I: next_addr = ptr_word;
            oag_pkg::OAG_IDXIND_S, oag_pkg::OAG_IDXIND_L: next_addr = ptr_word + idx;
            default:                next_addr = 16'h0000;
        endcase
        case (mode)
            oag_pkg::OAG_REL_I:                             rel_off = ptr[0];
            oag_pkg::OAG_BITREL_D, oag_pkg::OAG_BITREL_I:   rel_off = opnd[1];
            default:                                        rel_off = opnd[0];
        endcase
        next_target = pc_next + {{8{rel_off[7]}}, rel_off};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_valid     <= 1'b0;
            mode_out       <= oag_pkg::OAG_INH;
            operand_addr   <= 16'h0000;
            operand_value  <= 8'h00;
            jump_target    <= 16'h0000;
            bit_number     <= 3'd0;
            instr_len      <= 3'd0;
            use_y_out      <= 1'b0;
            short_only_out <= 1'b0;
        end else begin
            addr_valid <= (state == oag_pkg::ST_CALC);
            if (state == oag_pkg::ST_CALC) begin
                mode_out       <= mode;
                operand_addr   <= next_addr;
                operand_value  <= opnd[0];
                jump_target    <= next_target;
                bit_number     <= bit_sel;
                instr_len      <= len;
                use_y_out      <= use_y;
                short_only_out <= short_only;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ptr_read;
        mem_rd_req ##1 !mem_rd_req;
    endsequence
    sequence s_result;
        addr_valid;
    endsequence
    property p_inherent;
        s_result and mode_out == oag_pkg::OAG_INH |-> instr_len == `OAG_LEN_OPC + {2'b00, had_pfx};
    endproperty
    a_inherent: assert property (p_inherent) else $error("inherent length wrong");
    property p_immediate;
        s_result and mode_out == oag_pkg::OAG_IMM |-> operand_value == opnd[0];
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate value wrong");
    property p_dir_s;
        s_result and mode_out == oag_pkg::OAG_DIR_S |-> operand_addr == {`OAG_PAGE0_HI, opnd[0]};
    endproperty
    a_dir_s: assert property (p_dir_s) else $error("short direct address wrong");
    property p_dir_l;
        s_result and mode_out == oag_pkg::OAG_DIR_L |-> operand_addr == {opnd[0], opnd[1]};
    endproperty
    a_dir_l: assert property (p_dir_l) else $error("long direct address wrong");
    property p_idx_s;
        s_result and mode_out == oag_pkg::OAG_IDX_S |->
            operand_addr <= `OAG_IDXS_MAX && operand_addr == {`OAG_PAGE0_HI, opnd[0]} + $past(idx);
    endproperty
    a_idx_s: assert property (p_idx_s) else $error("short indexed address wrong");
    property p_ptr_page0;
        mem_rd_req |-> mem_rd_addr[15:8] == `OAG_PAGE0_HI ##0 s_ptr_read;
    endproperty
    a_ptr_page0: assert property (p_ptr_page0) else $error("pointer read off page zero");
    property p_ind_via_read;
        last_opnd && indirect |-> ##2 s_ptr_read;
    endproperty
    a_ind_via_read: assert property (p_ind_via_read) else $error("indirect without pointer read");
    property p_rel;
        s_result and mode_out == oag_pkg::OAG_REL_D |->
            jump_target == $past(pc_next) + {{8{opnd[0][7]}}, opnd[0]};
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_prefix_y;
        (state == oag_pkg::ST_IDLE) && fetch_valid && (fetch_byte == `OAG_PFX_ALT) ##1 take_opc |=> use_y;
    endproperty
    a_prefix_y: assert property (p_prefix_y) else $error("prefix did not select Y");
endmodule

// >>> tb/oag_mem_model.sv
// Page-zero pointer memory on the far side of the pointer read port
`timescale 1ns/10ps

module oag_mem_model (
    // Clock, reset and answer delay
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  latency,
    // Pointer read port
    input  wire logic        mem_rd_req,
    input  wire logic [15:0] mem_rd_addr,
    output logic             mem_rd_valid,
    output logic [7:0]       mem_rd_data
);
    logic       busy;
    logic [3:0] wait_cnt;
    logic [7:0] held;

    // Content of a page-zero byte is its address plus 40
    always_ff @(posedge clk) begin
        if (reset) begin
            busy         <= 1'b0;
            wait_cnt     <= 4'h0;
            mem_rd_valid <= 1'b0;
            held         <= 8'h00;
        end else begin
            mem_rd_valid <= 1'b0;
            if (mem_rd_req) begin
                busy     <= 1'b1;
                wait_cnt <= latency;
                held     <= mem_rd_addr[7:0] + 8'h40;
            end else if (busy && wait_cnt == 4'h0) begin
                busy         <= 1'b0;
                mem_rd_valid <= 1'b1;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end

    // Stale data is inverted outside the answer cycle
    assign mem_rd_data = mem_rd_valid ? held : ~held;
endmodule

// >>> tb/cpu_operand_address_generator_bench.sv
// Testbench of the operand address generator
`timescale 1ns/10ps

module cpu_operand_address_generator_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic               clk;
    logic               reset;
    logic               fetch_valid;
    logic [7:0]         fetch_byte;
    logic [15:0]        fetch_pc;
    logic [7:0]         idx_x;
    logic [7:0]         idx_y;
    logic [3:0]         latency;
    logic               mem_rd_req;
    logic [15:0]        mem_rd_addr;
    logic               mem_rd_valid;
    logic [7:0]         mem_rd_data;
    logic               addr_valid;
    oag_pkg::oag_mode_e mode_out;
    logic [15:0]        operand_addr;
    logic [7:0]         operand_value;
    logic [15:0]        jump_target;
    logic [2:0]         bit_number;
    logic [2:0]         instr_len;
    logic               use_y_out;
    logic               short_only_out;
    int                 failures;
    int                 checks_done;

    oag_core oag_core_i (.clk(clk), .reset(reset), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_pc(fetch_pc), .idx_x(idx_x), .idx_y(idx_y), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .addr_valid(addr_valid), .mode_out(mode_out),
        .operand_addr(operand_addr), .operand_value(operand_value), .jump_target(jump_target),
        .bit_number(bit_number), .instr_len(instr_len), .use_y_out(use_y_out), .short_only_out(short_only_out));

    oag_mem_model oag_mem_model_i (.clk(clk), .reset(reset), .latency(latency), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic run(input logic [31:0] code, input int n, input logic [15:0] pc);
        int k;
        for (k = 0; k < n; k++) begin
            @(negedge clk);
            fetch_valid = 1'b1;
            fetch_byte = code[8*(n-1-k) +: 8];
            fetch_pc = pc + 16'(k);
        end
        @(negedge clk);
        fetch_valid = 1'b0;
        for (k = 0; k < 60 && addr_valid !== 1'b1; k++)
            @(negedge clk);
        chk("addr_valid", 16'h1, {15'h0, addr_valid});
    endtask

    task automatic res(input oag_pkg::oag_mode_e m, input logic [2:0] l);
        chk("mode", 16'(m), 16'(mode_out));
        chk("instr_len", 16'(l), 16'(instr_len));
    endtask

    task give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_plain;
        run(32'h9D, 1, 16'h0100);
        res(oag_pkg::OAG_INH, 3'h1);
        run(32'hA655, 2, 16'h0100);
        res(oag_pkg::OAG_IMM, 3'h2);
        chk("value", 16'h0055, 16'(operand_value));
        run(32'hB6F0, 2, 16'h0100);
        res(oag_pkg::OAG_DIR_S, 3'h2);
        chk("addr", 16'h00F0, operand_addr);
        chk("short_only", 16'h0, 16'(short_only_out));
        run(32'hC61234, 3, 16'h0100);
        res(oag_pkg::OAG_DIR_L, 3'h3);
        chk("addr", 16'h1234, operand_addr);
    endtask

    task t_indexed;
        idx_x = 8'h7F;
        idx_y = 8'h80;
        run(32'hF6, 1, 16'h0100);
        res(oag_pkg::OAG_IDX_0, 3'h1);
        chk("addr", 16'h007F, operand_addr);
        run(32'h90F6, 2, 16'h0100);
        res(oag_pkg::OAG_IDX_0, 3'h2);
        chk("addr", 16'h0080, operand_addr);
        chk("use_y", 16'h1, 16'(use_y_out));
        idx_y = 8'hFF;
        run(32'h90E6FF, 3, 16'h0100);
        res(oag_pkg::OAG_IDX_S, 3'h3);
        chk("addr", 16'h01FE, operand_addr);
        idx_x = 8'h80;
        run(32'hD61080, 3, 16'h0100);
        res(oag_pkg::OAG_IDX_L, 3'h3);
        chk("addr", 16'h1100, operand_addr);
    endtask

    task t_indirect;
        latency = 4'h0;
        run(32'h92B610, 3, 16'h0100);
        res(oag_pkg::OAG_IND_S, 3'h3);
        chk("addr", 16'h0050, operand_addr);
        latency = 4'h5;
        run(32'h92C620, 3, 16'h0100);
        res(oag_pkg::OAG_IND_L, 3'h3);
        chk("addr", 16'h6061, operand_addr);
        idx_x = 8'hF0;
        run(32'h92E630, 3, 16'h0100);
        res(oag_pkg::OAG_IDXIND_S, 3'h3);
        chk("addr", 16'h0160, operand_addr);
        idx_y = 8'h01;
        run(32'h91D630, 3, 16'h0100);
        res(oag_pkg::OAG_IDXIND_L, 3'h3);
        chk("addr", 16'h7072, operand_addr);
    endtask

    task t_relative;
        run(32'h2080, 2, 16'h1000);
        res(oag_pkg::OAG_REL_D, 3'h2);
        chk("target", 16'h0F82, jump_target);
        run(32'h207F, 2, 16'h1000);
        chk("target", 16'h1081, jump_target);
        run(32'h922040, 3, 16'h2000);
        res(oag_pkg::OAG_REL_I, 3'h3);
        chk("target", 16'h1F83, jump_target);
    endtask

    task t_bit;
        run(32'h1A10, 2, 16'h0100);
        res(oag_pkg::OAG_BIT_D, 3'h2);
        chk("bit", 16'h5, 16'(bit_number));
        chk("short_only", 16'h1, 16'(short_only_out));
        run(32'h0F1005, 3, 16'h0300);
        res(oag_pkg::OAG_BITREL_D, 3'h3);
        chk("target", 16'h0308, jump_target);
        run(32'h920E1005, 4, 16'h0400);
        res(oag_pkg::OAG_BITREL_I, 3'h4);
        chk("addr", 16'h0050, operand_addr);
        chk("target", 16'h0409, jump_target);
        run(32'h3C10, 2, 16'h0100);
        chk("short_only", 16'h1, 16'(short_only_out));
    endtask

    task t_reset;
        @(negedge clk);
        fetch_valid = 1'b1;
        fetch_byte = 8'h90;
        @(negedge clk);
        reset = 1'b1;
        fetch_valid = 1'b0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk("addr_valid", 16'h0, {15'h0, addr_valid});
        chk("mode", 16'h0, 16'(mode_out));
        chk("addr", 16'h0, operand_addr);
        run(32'hF6, 1, 16'h0100);
        res(oag_pkg::OAG_IDX_0, 3'h1);
        chk("addr", 16'h00F0, operand_addr);
        chk("use_y", 16'h0, 16'(use_y_out));
    endtask

    initial begin
        #200000;
        failures++;
        give_verdict;
    end

    initial begin
        failures = 0;
        checks_done = 0;
        reset = 1'b1;
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        fetch_pc = 16'h0000;
        idx_x = 8'h00;
        idx_y = 8'h00;
        latency = 4'h0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("mode", 16'h0, 16'(mode_out));
        t_plain;
        t_indexed;
        t_indirect;
        t_relative;
        t_bit;
        t_reset;
        give_verdict;
    end
endmodule
